// ### opdec_pkg.sv
package opdec_pkg;

	// ----------------------------------------
	// Addressing modes
	// ----------------------------------------
	typedef enum logic [3:0] {
		MODE_NONE,
		MODE_IMPLIED,
		MODE_IMMEDIATE,
		MODE_PAGE,
		MODE_PAGE_BRANCH,
		MODE_RELATIVE,
		MODE_FULL_ADDRESS,
		MODE_INDEX_PLAIN,
		MODE_INDEX_SHORT,
		MODE_INDEX_LONG
	} opdec_mode_e;

	// ----------------------------------------
	// Operations decoded by this slice
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_OTHER,
		OP_COPY_ACC_TO_INDEX,
		OP_COPY_INDEX_TO_ACC,
		OP_TEST_BYTE_ZERO,
		OP_TEST_ACC_ZERO,
		OP_TEST_INDEX_ZERO
	} opdec_op_e;

	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OPC_COPY_ACC_TO_INDEX = 8'h97;
	localparam logic [7:0] OPC_COPY_INDEX_TO_ACC = 8'h9F;
	localparam logic [3:0] ROW_TEST              = 4'hD;
	localparam logic [3:0] COL_TEST_PAGE         = 4'h3;
	localparam logic [3:0] COL_TEST_ACC          = 4'h4;
	localparam logic [3:0] COL_TEST_INDEX        = 4'h5;
	localparam logic [3:0] COL_TEST_SHORT        = 4'h6;
	localparam logic [3:0] COL_TEST_PLAIN        = 4'h7;

	// ----------------------------------------
	// Cycle counts
	// ----------------------------------------
	localparam logic [3:0] CYC_COPY       = 4'h2;
	localparam logic [3:0] CYC_TEST_PAGE  = 4'h4;
	localparam logic [3:0] CYC_TEST_REG   = 4'h3;
	localparam logic [3:0] CYC_TEST_SHORT = 4'h5;
	localparam logic [3:0] CYC_TEST_PLAIN = 4'h4;

	// ----------------------------------------
	// Operand byte counts
	// ----------------------------------------
	localparam logic [1:0] BYTES_NONE = 2'h0;
	localparam logic [1:0] BYTES_ONE  = 2'h1;
	localparam logic [1:0] BYTES_TWO  = 2'h2;

	// Reset values
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [7:0]  ZERO_BYTE = 8'h00;

endpackage

// ### opdec_table.sv
`timescale 1ns/1ps

// Combinational opcode table for the transfer and test rows
module opdec_table (
	// Opcode in
	input  wire logic [7:0]           opcode,
	// Decoded attributes
	output opdec_pkg::opdec_mode_e    mode,
	output opdec_pkg::opdec_op_e      op,
	output logic [1:0]                nbytes,
	output logic [3:0]                ncycles,
	output logic                      known,
	output logic                      ccr_keep
);

	// ----------------------------------------
	// Column and row split
	// ----------------------------------------
	wire logic [3:0] col = opcode[7:4];
	wire logic [3:0] row = opcode[3:0];

	// Column addressing class
	function automatic opdec_pkg::opdec_mode_e col_mode(input logic [3:0] c);
		case (c)
			4'h0:       col_mode = opdec_pkg::MODE_PAGE_BRANCH;
			4'h2:       col_mode = opdec_pkg::MODE_RELATIVE;
			4'h1, 4'h3, 4'hB: col_mode = opdec_pkg::MODE_PAGE;
			4'h4, 4'h5, 4'h8, 4'h9: col_mode = opdec_pkg::MODE_IMPLIED;
			4'h6, 4'hE: col_mode = opdec_pkg::MODE_INDEX_SHORT;
			4'h7, 4'hF: col_mode = opdec_pkg::MODE_INDEX_PLAIN;
			4'hA:       col_mode = opdec_pkg::MODE_IMMEDIATE;
			4'hC:       col_mode = opdec_pkg::MODE_FULL_ADDRESS;
			default:    col_mode = opdec_pkg::MODE_INDEX_LONG;
		endcase
	endfunction

	// Operand bytes per mode
	function automatic logic [1:0] mode_bytes(input opdec_pkg::opdec_mode_e m);
		case (m)
			opdec_pkg::MODE_PAGE_BRANCH, opdec_pkg::MODE_FULL_ADDRESS,
			opdec_pkg::MODE_INDEX_LONG: mode_bytes = opdec_pkg::BYTES_TWO;
			opdec_pkg::MODE_IMPLIED, opdec_pkg::MODE_INDEX_PLAIN,
			opdec_pkg::MODE_NONE:       mode_bytes = opdec_pkg::BYTES_NONE;
			default:                    mode_bytes = opdec_pkg::BYTES_ONE;
		endcase
	endfunction

	// ----------------------------------------
	// Recognised opcodes
	// ----------------------------------------
	always_comb begin
		op       = opdec_pkg::OP_OTHER;
		ncycles  = 4'h0;
		known    = 1'b0;
		ccr_keep = 1'b0;
		mode     = col_mode(col); // Class still sizes unknown opcodes outside row D
		if (opcode == opdec_pkg::OPC_COPY_ACC_TO_INDEX) begin
			op       = opdec_pkg::OP_COPY_ACC_TO_INDEX;
			ncycles  = opdec_pkg::CYC_COPY;
			ccr_keep = 1'b1;
			known    = 1'b1;
			mode     = opdec_pkg::MODE_IMPLIED;
		end else if (opcode == opdec_pkg::OPC_COPY_INDEX_TO_ACC) begin
			op       = opdec_pkg::OP_COPY_INDEX_TO_ACC;
			ncycles  = opdec_pkg::CYC_COPY;
			ccr_keep = 1'b1;
			known    = 1'b1;
			mode     = opdec_pkg::MODE_IMPLIED;
		end else if (row == opdec_pkg::ROW_TEST) begin
			known = 1'b1;
			mode  = col_mode(col);
			case (col)
				opdec_pkg::COL_TEST_PAGE: begin
					op      = opdec_pkg::OP_TEST_BYTE_ZERO;
					ncycles = opdec_pkg::CYC_TEST_PAGE;
				end
				opdec_pkg::COL_TEST_ACC: begin
					op      = opdec_pkg::OP_TEST_ACC_ZERO;
					ncycles = opdec_pkg::CYC_TEST_REG;
				end
				opdec_pkg::COL_TEST_INDEX: begin
					op      = opdec_pkg::OP_TEST_INDEX_ZERO;
					ncycles = opdec_pkg::CYC_TEST_REG;
				end
				opdec_pkg::COL_TEST_SHORT: begin
					op      = opdec_pkg::OP_TEST_BYTE_ZERO;
					ncycles = opdec_pkg::CYC_TEST_SHORT;
				end
				opdec_pkg::COL_TEST_PLAIN: begin
					op      = opdec_pkg::OP_TEST_BYTE_ZERO;
					ncycles = opdec_pkg::CYC_TEST_PLAIN;
				end
				default: begin
					known = 1'b0;
					mode  = opdec_pkg::MODE_NONE;
				end
			endcase
		end
	end

	// Operand count follows the mode
	assign nbytes = mode_bytes(mode);

endmodule // opdec_table

// ### opdec_core.sv
`timescale 1ns/1ps

// How it works
// - Opcode 97 copies the accumulator into the index register in 2 cycles, flags untouched.
// - Opcode 9F copies the index register into the accumulator in 2 cycles, flags untouched.
// - Test-against-zero decodes 3D/4D/5D/6D/7D at 4/3/3/5/4 cycles, result discarded.
// - Page mode takes one byte as a first-page address, then a branch offset in bit-branch forms.
// - Short-offset indexed mode adds one offset byte to the index register.
// - Long-offset indexed mode adds a high-then-low offset pair to the index register.
// - Full-address mode takes a two-byte address, high byte first.
// - Relative branches take one offset byte, added to the program counter when taken.
// - Plain indexed mode uses the index register as the address with no operand byte.
// - The upper opcode nibble picks the column and class, the lower nibble the row.
module opdec_core (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	// Program memory byte stream
	input  wire logic [7:0]            prog_byte,
	input  wire logic                  prog_valid,
	output logic                       prog_ready,
	// Datapath context
	input  wire logic [7:0]            index_val,
	input  wire logic [15:0]           pc_val,
	input  wire logic                  branch_taken,
	// Decoded instruction
	output logic                       dec_valid,
	input  wire logic                  dec_ready,
	output opdec_pkg::opdec_op_e       dec_op,
	output opdec_pkg::opdec_mode_e     dec_mode,
	output logic [1:0]                 dec_nbytes,
	output logic [3:0]                 dec_ncycles,
	output logic                       dec_known,
	output logic                       dec_ccr_keep,
	output logic                       dec_discard,
	output logic [15:0]                dec_ea,
	output logic [7:0]                 dec_branch_offset,
	output logic [15:0]                dec_branch_target
);

	// ----------------------------------------
	// Fetch state
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_OPCODE,
		ST_OPERAND,
		ST_HOLD
	} opdec_state_e;

	opdec_state_e           state_r;
	opdec_state_e           state_nxt;
	logic [7:0]             opcode_r;
	logic [1:0]             left_r;
	logic [15:0]            bytes_r;

	opdec_pkg::opdec_mode_e t_mode;
	opdec_pkg::opdec_op_e   t_op;
	logic [1:0]             t_nbytes;
	logic [3:0]             t_ncycles;
	logic                   t_known;
	logic                   t_ccr_keep;

	// Table lookup on the opcode held
	opdec_table u_table (
		.opcode   (opcode_r),
		.mode     (t_mode),
		.op       (t_op),
		.nbytes   (t_nbytes),
		.ncycles  (t_ncycles),
		.known    (t_known),
		.ccr_keep (t_ccr_keep)
	);

	// ----------------------------------------
	// Handshakes
	// ----------------------------------------
	wire logic take_byte = prog_valid && prog_ready;
	wire logic last_byte = take_byte && (left_r == 2'h1);
	assign prog_ready = (state_r != ST_HOLD);
	assign dec_valid  = (state_r == ST_HOLD);

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OPCODE: if (take_byte) begin
				state_nxt = ST_OPERAND;
			end
			ST_OPERAND: if (left_r == 2'h0 || last_byte) begin
				state_nxt = ST_HOLD;
			end
			default: if (dec_ready) begin
				state_nxt = ST_OPCODE;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_OPCODE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Opcode capture
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			opcode_r <= opdec_pkg::ZERO_BYTE;
		end else if (state_r == ST_OPCODE && take_byte) begin
			opcode_r <= prog_byte;
		end
	end

	// Operand bytes left; loaded after the opcode is in
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			left_r <= 2'h0;
		end else if (state_r == ST_OPCODE) begin
			left_r <= 2'h3;
		end else if (state_r == ST_OPERAND && left_r == 2'h3) begin
			left_r <= t_nbytes;
		end else if (state_r == ST_OPERAND && take_byte && left_r != 2'h0) begin
			left_r <= left_r - 2'h1;
		end
	end

	// Operand bytes shift in, first of two ends up high, a single byte stays low
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bytes_r <= opdec_pkg::ZERO_WORD;
		end else if (state_r == ST_OPCODE) begin
			bytes_r <= opdec_pkg::ZERO_WORD;
		end else if (state_r == ST_OPERAND && take_byte && left_r != 2'h3 && left_r != 2'h0) begin
			bytes_r <= {bytes_r[7:0], prog_byte};
		end
	end

	// ----------------------------------------
	// Effective address and branch target
	// ----------------------------------------
	wire logic [15:0] idx16   = {8'h00, index_val};
	wire logic [15:0] short16 = {8'h00, bytes_r[7:0]};
	wire logic [7:0]  rel_b   = bytes_r[7:0];
	wire logic [15:0] rel16   = {{8{rel_b[7]}}, rel_b};
	// Page-branch forms: page address is first byte, offset the second
	wire logic [7:0]  page_b  = (t_mode == opdec_pkg::MODE_PAGE_BRANCH) ? bytes_r[15:8]
	                                                                       : bytes_r[7:0];
	wire logic        has_rel = (t_mode == opdec_pkg::MODE_RELATIVE)
	                          || (t_mode == opdec_pkg::MODE_PAGE_BRANCH);

	always_comb begin
		case (t_mode)
			opdec_pkg::MODE_PAGE, opdec_pkg::MODE_PAGE_BRANCH:
				dec_ea = {8'h00, page_b};
			opdec_pkg::MODE_INDEX_SHORT:
				dec_ea = idx16 + short16;
			opdec_pkg::MODE_INDEX_LONG:
				dec_ea = idx16 + bytes_r;
			opdec_pkg::MODE_FULL_ADDRESS:
				dec_ea = bytes_r;
			opdec_pkg::MODE_INDEX_PLAIN:
				dec_ea = idx16;
			default:
				dec_ea = opdec_pkg::ZERO_WORD;
		endcase
	end

	// Displacement applied only when taken
	assign dec_branch_offset = has_rel ? rel_b : opdec_pkg::ZERO_BYTE;
	assign dec_branch_target = (has_rel && branch_taken) ? pc_val + rel16 : pc_val;

	// ----------------------------------------
	// Decoded outputs
	// ----------------------------------------
	assign dec_op       = t_op;
	assign dec_mode     = t_mode;
	assign dec_nbytes   = t_nbytes;
	assign dec_ncycles  = t_ncycles;
	assign dec_known    = t_known;
	assign dec_ccr_keep = t_ccr_keep;
	// Test result is compared and thrown away
	assign dec_discard  = (t_op == opdec_pkg::OP_TEST_BYTE_ZERO)
	                   || (t_op == opdec_pkg::OP_TEST_ACC_ZERO)
	                   || (t_op == opdec_pkg::OP_TEST_INDEX_ZERO);

endmodule // opdec_core

// ### opdec_prog_mem.sv
`timescale 1ns/1ps

// Program memory model handing out one instruction at a time
module opdec_prog_mem (
	// Clock and handshake
	input  wire logic       ref_clk,
	input  wire logic       prog_ready,
	// Byte stream
	output logic [7:0]      prog_byte,
	output logic            prog_valid
);
	// Idle bus at time zero
	initial begin
		prog_byte  = 8'h5A;
		prog_valid = 1'b0;
	end

	// Hold a byte until an edge samples ready high
	task automatic put(input logic [7:0] b);
		prog_byte  = b;
		prog_valid = 1'b1;
		while (prog_ready !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	// Opcode, one idle cycle, then operands; released bus shows inverse
	task automatic send(input logic [7:0] op, b1, b2, input logic [1:0] n);
		put(op);
		prog_valid = 1'b0;
		prog_byte  = ~op;
		@(negedge ref_clk);
		if (n != 2'h0) put(b1);
		if (n == 2'h2) put(b2); // High byte first
		prog_valid = 1'b0;
		prog_byte  = ~prog_byte;
	endtask
endmodule // opdec_prog_mem

// ### opdec_core_checker.sv
`timescale 1ns/1ps

// Port checks of the transfer and test decode slice
module opdec_core_checker (
	// Clock, reset and stream
	input wire logic                   ref_clk, rst_b, prog_ready, branch_taken,
	input wire logic [7:0]             prog_byte, index_val, dec_branch_offset,
	// Decode side
	input wire logic                   dec_valid, dec_ready, dec_ccr_keep, dec_discard,
	input wire logic [1:0]             dec_nbytes,
	input wire logic [3:0]             dec_ncycles,
	input wire logic [15:0]            pc_val, dec_ea, dec_branch_target,
	input wire opdec_pkg::opdec_op_e   dec_op,
	input wire opdec_pkg::opdec_mode_e dec_mode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Mode flags and extended operands
	wire logic        m_pg = dec_mode == opdec_pkg::MODE_PAGE;
	wire logic        m_im = dec_mode == opdec_pkg::MODE_IMPLIED;
	wire logic        m_sh = dec_mode == opdec_pkg::MODE_INDEX_SHORT;
	wire logic        m_pl = dec_mode == opdec_pkg::MODE_INDEX_PLAIN;
	wire logic        m_lg = dec_mode == opdec_pkg::MODE_INDEX_LONG;
	wire logic        m_fa = dec_mode == opdec_pkg::MODE_FULL_ADDRESS;
	wire logic        m_rl = dec_mode == opdec_pkg::MODE_RELATIVE;
	wire logic [15:0] xi   = {8'h00, index_val};
	wire logic [15:0] rel  = {{8{dec_branch_offset[7]}}, dec_branch_offset};

	a_busy_refuse: assert property (dec_valid |-> !prog_ready)
		else $error("ready while decode held");
	a_decode_hold: assert property (dec_valid && !dec_ready |=> dec_valid
		&& $stable(dec_ea) && $stable(dec_op)) else $error("decode moved before accept");
	a_copy_fwd: assert property ($rose(dec_valid) && dec_op == opdec_pkg::OP_COPY_ACC_TO_INDEX
		|-> $past(prog_byte, 3) == 8'h97 && m_im && dec_ncycles == 4'h2 && dec_ccr_keep)
		else $error("acc to index decode");
	a_copy_back: assert property (dec_valid && dec_op == opdec_pkg::OP_COPY_INDEX_TO_ACC
		|-> m_im && dec_ncycles == 4'h2 && dec_ccr_keep && dec_nbytes == 2'h0)
		else $error("index to acc decode");
	a_test_cycles: assert property (dec_valid && dec_discard |-> !dec_ccr_keep
		&& (m_pg && dec_ncycles == 4'h4 || m_im && dec_ncycles == 4'h3
		|| m_sh && dec_ncycles == 4'h5 || m_pl && dec_ncycles == 4'h4)) else $error("test cycles");
	a_page_addr: assert property ($rose(dec_valid) && m_pg
		|-> dec_ea == {8'h00, $past(prog_byte)}) else $error("page address");
	a_short_addr: assert property ($rose(dec_valid) && m_sh
		|-> dec_ea == xi + {8'h00, $past(prog_byte)}) else $error("short offset address");
	a_long_addr: assert property ($rose(dec_valid) && m_lg
		|-> dec_ea == {$past(prog_byte, 2), $past(prog_byte)} + xi) else $error("long offset address");
	a_full_addr: assert property ($rose(dec_valid) && m_fa
		|-> dec_ea == {$past(prog_byte, 2), $past(prog_byte)}) else $error("full address");
	a_rel_target: assert property (dec_valid && m_rl
		|-> dec_branch_target == (branch_taken ? pc_val + rel : pc_val)) else $error("branch target");
	a_plain_addr: assert property (dec_valid && m_pl
		|-> dec_nbytes == 2'h0 && dec_ea == xi) else $error("plain index address");

	c_short: cover property ($rose(dec_valid) && m_sh);
	c_taken: cover property (dec_valid && m_rl && branch_taken);
	c_stall: cover property (dec_valid && !dec_ready ##1 dec_valid);
endmodule // opdec_core_checker

bind opdec_core opdec_core_checker u_chk (.*);

// ### opdec_core_tb.sv
`timescale 1ns/1ps

// Corner and random instructions through the decode slice
module opdec_core_tb;
	logic        ref_clk, rst_b, prog_valid, prog_ready, branch_taken, dec_valid, dec_ready;
	logic        dec_known, dec_ccr_keep, dec_discard;
	logic [7:0]  prog_byte, index_val, dec_branch_offset;
	logic [15:0] pc_val, dec_ea, dec_branch_target;
	logic [1:0]  dec_nbytes;
	logic [3:0]  dec_ncycles;
	opdec_pkg::opdec_op_e   dec_op;
	opdec_pkg::opdec_mode_e dec_mode;
	int          fails = 0;
	int          cmp_count = 0;
	logic [31:0] rng = 32'h000161A1;
	// Slice opcodes with cycles, operation and mode
	logic [7:0]  t_opc [7] = '{8'h97, 8'h9F, 8'h3D, 8'h4D, 8'h5D, 8'h6D, 8'h7D};
	logic [3:0]  t_cyc [7] = '{4'h2, 4'h2, 4'h4, 4'h3, 4'h3, 4'h5, 4'h4};
	opdec_pkg::opdec_op_e t_op [7] = '{opdec_pkg::OP_COPY_ACC_TO_INDEX,
		opdec_pkg::OP_COPY_INDEX_TO_ACC, opdec_pkg::OP_TEST_BYTE_ZERO, opdec_pkg::OP_TEST_ACC_ZERO,
		opdec_pkg::OP_TEST_INDEX_ZERO, opdec_pkg::OP_TEST_BYTE_ZERO, opdec_pkg::OP_TEST_BYTE_ZERO};
	opdec_pkg::opdec_mode_e t_md [7] = '{opdec_pkg::MODE_IMPLIED, opdec_pkg::MODE_IMPLIED,
		opdec_pkg::MODE_PAGE, opdec_pkg::MODE_IMPLIED, opdec_pkg::MODE_IMPLIED,
		opdec_pkg::MODE_INDEX_SHORT, opdec_pkg::MODE_INDEX_PLAIN};
	logic [3:0]  cols [9] = '{4'h0, 4'h1, 4'h2, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};

	opdec_core dut (.*);
	opdec_prog_mem mem (.ref_clk, .prog_ready, .prog_byte, .prog_valid);

	// Clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		#20000;
		fails++;
		end_sim();
	end

	// Random source, operand counts and addresses per column class
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	function automatic logic [1:0] exp_nb(input logic [7:0] o);
		case (o[7:4])
			4'h0, 4'hC, 4'hD: return 2'h2;
			4'h1, 4'h2, 4'h3, 4'h6, 4'hA, 4'hB, 4'hE: return 2'h1;
			default: return 2'h0;
		endcase
	endfunction
	function automatic logic [15:0] exp_ea(input logic [7:0] o, b1, b2, x);
		case (o[7:4])
			4'hC: return {b1, b2};
			4'hD: return {b1, b2} + {8'h00, x};
			4'h6, 4'hE: return {8'h00, b1} + {8'h00, x};
			4'h7, 4'hF: return {8'h00, x};
			default: return {8'h00, b1};
		endcase
	endfunction

	// Compare and count
	task automatic chk(input logic [15:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// One instruction in, check the held decode, stall, accept
	task automatic run(input int i, input logic [7:0] o, b1, b2, x);
		int n;
		n = 0;
		index_val = x;
		pc_val = 16'(xs());
		branch_taken = 1'(xs());
		mem.send(o, b1, b2, exp_nb(o));
		while (dec_valid !== 1'b1 && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		chk(dec_valid, 1'b1);
		chk(dec_nbytes, exp_nb(o));
		chk(dec_known, i >= 0);
		if (i >= 0) begin
			chk(dec_ncycles, t_cyc[i]);
			chk(dec_op, t_op[i]);
			chk(dec_mode, t_md[i]);
			chk(dec_ccr_keep, i < 2);
			chk(dec_discard, i >= 2);
		end
		if (!(o[7:4] inside {4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA})) chk(dec_ea, exp_ea(o, b1, b2, x));
		if (o[7:4] == 4'h0) chk(dec_branch_offset, b2);
		if (o[7:4] == 4'h2) chk(dec_branch_target, branch_taken ? pc_val + {{8{b1[7]}}, b1} : pc_val);
		repeat (xs() % 3) @(negedge ref_clk);
		chk(prog_ready, 1'b0);
		dec_ready = 1'b1;
		@(negedge ref_clk);
		dec_ready = 1'b0;
	endtask

	task automatic end_sim();
		$display("mismatches %0d of %0d compares", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Reset, corners, random mix, reset while a decode is held
	initial begin
		logic [31:0] r;
		logic [2:0]  s;
		rst_b = 1'b0;
		dec_ready = 1'b0;
		index_val = 8'h00;
		pc_val = 16'h0000;
		branch_taken = 1'b0;
		repeat (10) @(negedge ref_clk);
		chk(prog_ready, 1'b1);
		rst_b = 1'b1;
		for (int i = 0; i < 7; i++) run(i, t_opc[i], 8'hFF, 8'hFF, 8'hFF);
		run(-1, 8'hD6, 8'hFF, 8'hFF, 8'h02);
		run(-1, 8'h20, 8'h80, 8'h00, 8'h00);
		for (int k = 0; k < 60; k++) begin
			r = xs();
			s = 3'(r[7:5] % 7);
			if (r[4]) run(s, t_opc[s], r[23:16], r[31:24], r[15:8]);
			else run(-1, {cols[r[11:8] % 9], (r[3:0] == 4'hD) ? 4'hE : r[3:0]},
				r[23:16], r[31:24], r[15:8]);
		end
		mem.send(8'h97, 8'h00, 8'h00, 2'h0);
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b0;
		#1;
		chk(dec_valid, 1'b0);
		@(negedge ref_clk);
		rst_b = 1'b1;
		run(5, 8'h6D, 8'h01, 8'h00, 8'h7F);
		end_sim();
	end
endmodule // opdec_core_tb
